/* core/cse_defs.svh */
// Constants of the CPU status and interrupt entry block: special function
// register addresses, status word bit positions, vector and timing figures.
// Assumes it is included by bare name from the core module.
//
// How it works
// (RULE_01) Low and high pointer bytes form one 16-bit data pointer for indirect access.
// (RULE_02) Carry set on add carry-out or subtract borrow, cleared by other arithmetic.
// (RULE_03) Aux carry set on carry into or borrow from the high nibble, else cleared.
// (RULE_04) Two bank bits select register bank base 0x00, 0x08, 0x10 or 0x18.
// (RULE_05) Software must not move accumulator to a bank register right after a bank change.
// (RULE_06) Overflow set on signed add/subtract overflow, product above 255, divide by zero.
// (RULE_07) Add, add-with-carry, subtract, multiply and divide clear overflow otherwise.
// (RULE_08) Status bits 5 and 1 are plain software flags without hardware meaning.
// (RULE_09) Read-only parity bit always equals odd parity of the accumulator.
// (RULE_10) A second accumulator register is used by multiply and divide.
// (RULE_11) Twenty-two interrupt sources, each low or high priority.
// (RULE_12) A source event sets its pending flag regardless of enables.
// (RULE_13) Pending and enabled raises a request; long call to vector after instruction ends.
// (RULE_14) Routines end with return-from-interrupt; execution resumes where it left off.
// (RULE_15) A disabled interrupt's pending flag is ignored.
// (RULE_16) Per-source enables count only while global enable is one.
// (RULE_17) Selected flags clear on vectoring; software clears the others before return.
// (RULE_18) A flag still set after return re-enters after one further instruction.
// (RULE_19) Software setting a pending flag behaves like a real event.
// (RULE_20) Twelve sources are on-chip peripherals, up to ten are external.
// (RULE_21) High preempts low, nothing preempts high, equal priority by fixed order.
// (RULE_22) Pending flags decoded every cycle; fastest entry is one plus four cycles.
// (RULE_23) A hardware set in the same cycle as a software clear wins.
`ifndef CSE_DEFS_SVH
`define CSE_DEFS_SVH

// ----------------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------------
`define CSE_ADDR_PTR_LO     8'h82
`define CSE_ADDR_PTR_HI     8'h83
`define CSE_ADDR_PSW        8'hD0
`define CSE_ADDR_ACC        8'hE0
`define CSE_ADDR_ACC2       8'hF0

// ----------------------------------------------------------------------------
// Status word bit positions and reset values
// ----------------------------------------------------------------------------
`define CSE_PSW_CY          7
`define CSE_PSW_AC          6
`define CSE_PSW_F0          5
`define CSE_PSW_RS1         4
`define CSE_PSW_RS0         3
`define CSE_PSW_OV          2
`define CSE_PSW_F1          1
`define CSE_PSW_PAR         0
`define CSE_RST_BYTE        8'h00

// ----------------------------------------------------------------------------
// Interrupt figures and the multiply overflow limit
// ----------------------------------------------------------------------------
`define CSE_NUM_SRC         22
`define CSE_NUM_PERIPH      12
`define CSE_NUM_EXT         10
`define CSE_VEC_BASE        16'h0003
`define CSE_CALL_CYCLES     4
`define CSE_MUL_LIMIT       16'h00FF
`define CSE_AUTO_CLR        22'h0000_00

`endif

/* core/cse_pkg.sv */
// Types shared by the CPU status and interrupt entry block.
// Assumes cse_defs.svh holds the numeric constants.
package cse_pkg;

	// ------------------------------------------------------------------------
	// Arithmetic operations reported by the instruction decoder
	// ------------------------------------------------------------------------
	typedef enum logic [2:0] {
		CSE_OP_NONE = 3'b000,
		CSE_OP_ADD  = 3'b001,
		CSE_OP_ADD_WITH_CARRY_INSTR = 3'b010,
		CSE_OP_SUBTRACT_WITH_BORROW_INSTR = 3'b011,
		CSE_OP_MUL  = 3'b100,
		CSE_OP_DIV  = 3'b101
	} cse_op_t;

	// ------------------------------------------------------------------------
	// Interrupt entry sequencer
	// ------------------------------------------------------------------------
	typedef enum logic [0:0] {
		CSE_ST_RUN  = 1'b0,
		CSE_ST_CALL = 1'b1
	} cse_state_t;

endpackage : cse_pkg

/* core/cse_core.sv */
// CPU status registers (pointer, accumulators, status word) and the
// interrupt pending, arbitration and long-call entry sequencer.
// Assumes all inputs are synchronous to clk; pin events are synchronised
// and edge-detected by the peripheral that owns the pin.
`timescale 1ns/1ps
`include "cse_defs.svh"

module cse_core #(
	parameter int            NUM_SRC     = `CSE_NUM_SRC, // [RULE_11] [RULE_20]
	parameter int            CALL_CYCLES = `CSE_CALL_CYCLES,
	parameter logic [NUM_SRC-1:0] AUTO_CLR = `CSE_AUTO_CLR
) (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               rst_n,
	// Special function register port
	input  wire logic [7:0]         sfr_addr,
	input  wire logic               sfr_wr,
	input  wire logic [7:0]         sfr_wdata,
	output logic      [7:0]         sfr_rdata,
	// Arithmetic operation from the decoder
	input  wire logic               alu_valid,
	input  wire cse_pkg::cse_op_t   alu_op,
	input  wire logic [7:0]         alu_src,
	// Instruction boundaries
	input  wire logic               instr_done,
	input  wire logic               return_from_interrupt_instr_done,
	// Interrupt sources and control
	input  wire logic [NUM_SRC-1:0] irq_event,
	input  wire logic [NUM_SRC-1:0] pend_sw_set,
	input  wire logic [NUM_SRC-1:0] pend_sw_clr,
	input  wire logic [NUM_SRC-1:0] irq_enable,
	input  wire logic [NUM_SRC-1:0] irq_high_prio,
	input  wire logic               global_interrupt_enable,
	// Status outputs
	output logic      [15:0]        data_pointer,
	output logic      [7:0]         accumulator,
	output logic      [7:0]         second_accumulator,
	output logic      [7:0]         program_status_word,
	output logic      [4:0]         bank_base,
	output logic      [NUM_SRC-1:0] pend_flags,
	// Interrupt entry
	output logic                    call_busy,
	output logic                    vec_valid,
	output logic      [15:0]        vec_addr,
	output logic      [4:0]         vec_src,
	output logic                    in_high_isr,
	output logic                    in_low_isr
);

	// ------------------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------------------
	generate
		if (NUM_SRC < 1 || NUM_SRC > 32) begin : g_bad_src
			$error("NUM_SRC must lie between 1 and 32");
		end
		if (CALL_CYCLES < 1 || CALL_CYCLES > 7) begin : g_bad_call
			$error("CALL_CYCLES must lie between 1 and 7");
		end
	endgenerate

	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic [7:0]          ptr_lo;
		logic [7:0]          ptr_hi;
		logic [7:0]          acc;
		logic [7:0]          acc2;
		logic                cy;
		logic                ac;
		logic                f0;
		logic [1:0]          rs;
		logic                ov;
		logic                f1;
		logic                par;
		logic [7:0]          rdata;
		logic [NUM_SRC-1:0]  pend;
		logic                req;
		logic [4:0]          req_src;
		logic                req_hi;
		cse_pkg::cse_state_t state;
		logic [2:0]          cnt;
		logic                busy;
		logic                act_hi;
		logic                act_lo;
		logic                vvalid;
		logic [15:0]         vaddr;
		logic [4:0]          vsrc;
	} cse_core_state_t;

	localparam logic [2:0] CALL_LAST = 3'(CALL_CYCLES - 1);

	cse_core_state_t st_reg;
	cse_core_state_t st_next;

	logic rst_meta_reg;
	logic rst_sync_reg;

	// ------------------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	// ------------------------------------------------------------------------
	// Pending flags, one per source
	// ------------------------------------------------------------------------
	logic [NUM_SRC-1:0] pend_upd;
	logic [NUM_SRC-1:0] take_clr;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_SRC; gi++) begin : g_pend
			// Set terms come last so an event never loses to a clear
			assign pend_upd[gi] = (st_reg.pend[gi] & ~pend_sw_clr[gi] & ~take_clr[gi])
				| irq_event[gi]   // [RULE_12] [RULE_23]
				| pend_sw_set[gi]; // [RULE_19]
		end
	endgenerate

	// ------------------------------------------------------------------------
	// Arbitration
	// ------------------------------------------------------------------------
	logic [NUM_SRC-1:0] elig;
	logic [NUM_SRC-1:0] hi_cand;
	logic [NUM_SRC-1:0] lo_cand;
	logic               arb_req;
	logic [4:0]         arb_src;
	logic               arb_hi;

	always_comb begin
		// [RULE_15] [RULE_16]
		elig    = st_reg.pend & irq_enable & {NUM_SRC{global_interrupt_enable}};
		hi_cand = elig & irq_high_prio; // [RULE_11]
		lo_cand = elig & ~irq_high_prio;
		arb_req = 1'b0;
		arb_src = 5'h00;
		arb_hi  = 1'b0;
		// Descending scan: the lowest index found last wins [RULE_21]
		if (|hi_cand && !st_reg.act_hi) begin
			arb_req = 1'b1;
			arb_hi  = 1'b1;
			for (int i = NUM_SRC - 1; i >= 0; i--) begin
				if (hi_cand[i]) begin
					arb_src = 5'(i);
				end
			end
		end else if (|lo_cand && !st_reg.act_hi && !st_reg.act_lo) begin
			arb_req = 1'b1;
			for (int i = NUM_SRC - 1; i >= 0; i--) begin
				if (lo_cand[i]) begin
					arb_src = 5'(i);
				end
			end
		end
	end

	// ------------------------------------------------------------------------
	// Arithmetic
	// ------------------------------------------------------------------------
	logic        cin;
	logic [8:0]  sum9;
	logic [4:0]  sum_nib;
	logic [8:0]  dif9;
	logic [4:0]  dif_nib;
	logic [15:0] prod;

	always_comb begin
		cin     = (alu_op == cse_pkg::CSE_OP_ADD) ? 1'b0 : st_reg.cy;
		sum9    = {1'b0, st_reg.acc} + {1'b0, alu_src} + {8'h00, cin};
		sum_nib = {1'b0, st_reg.acc[3:0]} + {1'b0, alu_src[3:0]} + {4'h0, cin};
		dif9    = {1'b0, st_reg.acc} - {1'b0, alu_src} - {8'h00, st_reg.cy};
		dif_nib = {1'b0, st_reg.acc[3:0]} - {1'b0, alu_src[3:0]} - {4'h0, st_reg.cy};
		prod    = {8'h00, st_reg.acc} * {8'h00, st_reg.acc2};
	end

	// ------------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------------
	logic take;

	always_comb begin
		st_next  = st_reg;
		take_clr = '0;
		// Boundary of an ordinary instruction only; the return itself is not one,
		// so a flag left set re-enters after the following instruction [RULE_18]
		take     = (st_reg.state == cse_pkg::CSE_ST_RUN) && instr_done && !return_from_interrupt_instr_done
			&& st_reg.req; // [RULE_13]
		if (take && AUTO_CLR[st_reg.req_src]) begin
			take_clr[st_reg.req_src] = 1'b1; // [RULE_17]
		end

		// Arithmetic flag updates
		if (alu_valid) begin
			unique case (alu_op)
				cse_pkg::CSE_OP_ADD, cse_pkg::CSE_OP_ADD_WITH_CARRY_INSTR: begin
					st_next.acc = sum9[7:0];
					st_next.cy  = sum9[8];    // [RULE_02]
					st_next.ac  = sum_nib[4]; // [RULE_03]
					st_next.ov  = (st_reg.acc[7] == alu_src[7])
						&& (sum9[7] != st_reg.acc[7]); // [RULE_06] [RULE_07]
				end
				cse_pkg::CSE_OP_SUBTRACT_WITH_BORROW_INSTR: begin
					st_next.acc = dif9[7:0];
					st_next.cy  = dif9[8];    // [RULE_02]
					st_next.ac  = dif_nib[4]; // [RULE_03]
					st_next.ov  = (st_reg.acc[7] != alu_src[7])
						&& (dif9[7] != st_reg.acc[7]); // [RULE_06] [RULE_07]
				end
				cse_pkg::CSE_OP_MUL: begin
					st_next.acc  = prod[7:0];  // [RULE_10]
					st_next.acc2 = prod[15:8];
					st_next.cy   = 1'b0;       // [RULE_02]
					st_next.ac   = 1'b0;       // [RULE_03]
					st_next.ov   = (prod > `CSE_MUL_LIMIT); // [RULE_06] [RULE_07]
				end
				cse_pkg::CSE_OP_DIV: begin
					st_next.cy = 1'b0; // [RULE_02]
					st_next.ac = 1'b0; // [RULE_03]
					// Divide by zero leaves both accumulators untouched
					if (st_reg.acc2 == 8'h00) begin
						st_next.ov = 1'b1; // [RULE_06]
					end else begin
						st_next.acc  = st_reg.acc / st_reg.acc2; // [RULE_10]
						st_next.acc2 = st_reg.acc % st_reg.acc2;
						st_next.ov   = 1'b0; // [RULE_07]
					end
				end
				default: begin
				end
			endcase
		end

		// Software writes land after the arithmetic, so they win on a clash
		if (sfr_wr) begin
			unique case (sfr_addr)
				`CSE_ADDR_PTR_LO: st_next.ptr_lo = sfr_wdata; // [RULE_01]
				`CSE_ADDR_PTR_HI: st_next.ptr_hi = sfr_wdata; // [RULE_01]
				`CSE_ADDR_ACC:    st_next.acc    = sfr_wdata;
				`CSE_ADDR_ACC2:   st_next.acc2   = sfr_wdata; // [RULE_10]
				`CSE_ADDR_PSW: begin
					st_next.cy = sfr_wdata[`CSE_PSW_CY];
					st_next.ac = sfr_wdata[`CSE_PSW_AC];
					st_next.f0 = sfr_wdata[`CSE_PSW_F0]; // [RULE_08]
					st_next.rs = sfr_wdata[`CSE_PSW_RS1:`CSE_PSW_RS0]; // [RULE_04]
					st_next.ov = sfr_wdata[`CSE_PSW_OV];
					st_next.f1 = sfr_wdata[`CSE_PSW_F1]; // [RULE_08]
				end
				default: begin
				end
			endcase
		end

		// Parity tracks the accumulator value being stored
		st_next.par = ^st_next.acc; // [RULE_09]

		// Register read, answered one cycle later; unmapped reads give zero
		unique case (sfr_addr)
			`CSE_ADDR_PTR_LO: st_next.rdata = st_reg.ptr_lo;
			`CSE_ADDR_PTR_HI: st_next.rdata = st_reg.ptr_hi;
			`CSE_ADDR_ACC:    st_next.rdata = st_reg.acc;
			`CSE_ADDR_ACC2:   st_next.rdata = st_reg.acc2;
			`CSE_ADDR_PSW:    st_next.rdata = {st_reg.cy, st_reg.ac, st_reg.f0, st_reg.rs,
				st_reg.ov, st_reg.f1, st_reg.par};
			default:          st_next.rdata = 8'h00;
		endcase

		// Pending flags and the registered detect stage
		st_next.pend    = pend_upd;
		st_next.req     = arb_req;  // [RULE_22]
		st_next.req_src = arb_src;
		st_next.req_hi  = arb_hi;
		st_next.vvalid  = 1'b0;

		// Return-from-interrupt closes the most urgent active level
		if (return_from_interrupt_instr_done) begin
			if (st_reg.act_hi) begin
				st_next.act_hi = 1'b0; // [RULE_14]
			end else begin
				st_next.act_lo = 1'b0; // [RULE_14]
			end
		end

		// Long-call sequencer
		unique case (st_reg.state)
			cse_pkg::CSE_ST_RUN: begin
				if (take) begin
					st_next.state = cse_pkg::CSE_ST_CALL;
					st_next.cnt   = 3'h0;
					st_next.busy  = 1'b1;
					st_next.vsrc  = st_reg.req_src;
					st_next.vaddr = `CSE_VEC_BASE + {8'h00, st_reg.req_src, 3'b000};
					if (st_reg.req_hi) begin
						st_next.act_hi = 1'b1; // [RULE_21]
					end else begin
						st_next.act_lo = 1'b1;
					end
				end
			end
			cse_pkg::CSE_ST_CALL: begin
				// Request stage is stale while the call runs; re-sampled after
				st_next.req = 1'b0;
				if (st_reg.cnt == CALL_LAST) begin
					st_next.state  = cse_pkg::CSE_ST_RUN;
					st_next.busy   = 1'b0;
					st_next.vvalid = 1'b1; // [RULE_13] [RULE_22]
				end else begin
					st_next.cnt = st_reg.cnt + 3'h1;
				end
			end
		endcase
	end

	// ------------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			st_reg       <= '0;
			st_reg.acc   <= `CSE_RST_BYTE;
			st_reg.state <= cse_pkg::CSE_ST_RUN;
		end else begin
			st_reg <= st_next;
		end
	end

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------
	assign sfr_rdata           = st_reg.rdata;
	assign data_pointer        = {st_reg.ptr_hi, st_reg.ptr_lo}; // [RULE_01]
	assign accumulator         = st_reg.acc;
	assign second_accumulator  = st_reg.acc2;
	assign program_status_word = {st_reg.cy, st_reg.ac, st_reg.f0, st_reg.rs,
		st_reg.ov, st_reg.f1, st_reg.par};
	assign bank_base           = {st_reg.rs, 3'b000}; // [RULE_04]
	assign pend_flags          = st_reg.pend;
	assign call_busy           = st_reg.busy;
	assign vec_valid           = st_reg.vvalid;
	assign vec_addr            = st_reg.vaddr;
	assign vec_src             = st_reg.vsrc;
	assign in_high_isr         = st_reg.act_hi;
	assign in_low_isr          = st_reg.act_lo;

endmodule : cse_core

/* verif/cse_core_chk.sv */
// Concurrent checks on the ports of the status and interrupt entry core.
// Assumes default CALL_CYCLES (4) and AUTO_CLR (none cleared on vectoring).
`timescale 1ns/1ps
module cse_core_chk #(
	parameter int NUM_SRC = 22
) (
	input wire logic               clk,
	input wire logic               rst_n,
	input wire logic               sfr_wr,
	input wire logic               alu_valid,
	input wire cse_pkg::cse_op_t   alu_op,
	input wire logic [7:0]         alu_src,
	input wire logic               instr_done,
	input wire logic               return_from_interrupt_instr_done,
	input wire logic [NUM_SRC-1:0] irq_event,
	input wire logic [NUM_SRC-1:0] pend_sw_set,
	input wire logic               global_interrupt_enable,
	input wire logic [7:0]         accumulator,
	input wire logic [7:0]         program_status_word,
	input wire logic [4:0]         bank_base,
	input wire logic [NUM_SRC-1:0] pend_flags,
	input wire logic               call_busy,
	input wire logic               vec_valid,
	input wire logic [15:0]        vec_addr,
	input wire logic [4:0]         vec_src,
	input wire logic               in_high_isr
);
	// ------------------------------------------------------------------
	// Helper logic and sequences
	// ------------------------------------------------------------------
	logic [8:0] add_sum;
	logic       add_ovf;
	assign add_sum = {1'b0, accumulator} + {1'b0, alu_src};
	assign add_ovf = (accumulator[7] == alu_src[7]) && (add_sum[7] != accumulator[7]);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_take;
		$rose(call_busy);
	endsequence
	sequence s_call;
		call_busy[*4] ##1 (vec_valid && !call_busy);
	endsequence
	chk_parity_follows: assert property (program_status_word[0] == ^accumulator)
		else $error("parity bit differs from accumulator");
	chk_bank_base_map: assert property (bank_base == {program_status_word[4:3], 3'b000})
		else $error("bank base does not match bank bits");
	chk_call_length: assert property (s_take |-> s_call)
		else $error("long call length wrong");
	chk_vector_addr: assert property (vec_valid |-> vec_addr == 16'h0003 + {8'h00, vec_src, 3'b000})
		else $error("vector address does not match source");
	chk_take_point: assert property (s_take |-> $past(instr_done) && !$past(return_from_interrupt_instr_done))
		else $error("call started off an instruction boundary");
	chk_no_preempt_high: assert property (s_take |-> !$past(in_high_isr))
		else $error("high routine preempted");
	chk_global_off: assert property (!global_interrupt_enable[*4] |-> !$rose(call_busy))
		else $error("call started with global enable off");
	chk_pend_set: assert property ((irq_event | pend_sw_set) != '0
		|=> (pend_flags & $past(irq_event | pend_sw_set)) == $past(irq_event | pend_sw_set))
		else $error("pending flag not set by event");
	chk_add_flags: assert property (alu_valid && alu_op == cse_pkg::CSE_OP_ADD && !sfr_wr
		|=> {program_status_word[7], accumulator} == $past(add_sum)
		&& program_status_word[2] == $past(add_ovf))
		else $error("add result or flags wrong");
endmodule : cse_core_chk

bind cse_core cse_core_chk #(.NUM_SRC(NUM_SRC)) cse_core_chk_inst (.clk(clk), .rst_n(rst_n),
	.sfr_wr(sfr_wr), .alu_valid(alu_valid), .alu_op(alu_op), .alu_src(alu_src),
	.instr_done(instr_done), .return_from_interrupt_instr_done(return_from_interrupt_instr_done), .irq_event(irq_event),
	.pend_sw_set(pend_sw_set), .global_interrupt_enable(global_interrupt_enable),
	.accumulator(accumulator), .program_status_word(program_status_word),
	.bank_base(bank_base), .pend_flags(pend_flags), .call_busy(call_busy),
	.vec_valid(vec_valid), .vec_addr(vec_addr), .vec_src(vec_src), .in_high_isr(in_high_isr));

/* verif/cse_src_model.sv */
// Model of the peripherals and pins that raise interrupt events.
// Assumes events are already synchronised: one-cycle pulse per event.
`timescale 1ns/1ps
module cse_src_model #(
	parameter int NUM_SRC = 22
) (
	input wire logic               clk,
	input wire logic               rst_n,
	input wire logic               fire,
	input wire logic [NUM_SRC-1:0] fire_mask,
	output logic     [NUM_SRC-1:0] irq_event
);
	// Any of the peripheral or pin sources may fire, several at once
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			irq_event <= '0;
		else
			irq_event <= fire ? fire_mask : '0;
	end
endmodule : cse_src_model

/* verif/cse_core_tb.sv */
// Self-checking bench for the status and interrupt entry core.
// Assumes the core, its package and the event source model.
`timescale 1ns/1ps
module cse_core_tb;
	localparam int N = 22;
	logic             clk, rst_n, sfr_wr, alu_valid, instr_done, return_from_interrupt_instr_done, fire;
	logic             global_interrupt_enable, call_busy, vec_valid, in_high_isr, in_low_isr;
	logic [7:0]       sfr_addr, sfr_wdata, sfr_rdata, alu_src;
	logic [7:0]       accumulator, second_accumulator, program_status_word;
	cse_pkg::cse_op_t alu_op;
	logic [N-1:0]     irq_event, pend_sw_set, pend_sw_clr, irq_enable, irq_high_prio;
	logic [N-1:0]     pend_flags, fire_mask;
	logic [15:0]      data_pointer, vec_addr;
	logic [4:0]       bank_base, vec_src;
	int               err_total, samples_checked;
	logic [7:0]       regs [6] = '{8'h82, 8'h83, 8'hD0, 8'hE0, 8'hF0, 8'h81};

	cse_core cse_core_inst (.clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
		.sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .alu_valid(alu_valid), .alu_op(alu_op),
		.alu_src(alu_src), .instr_done(instr_done), .return_from_interrupt_instr_done(return_from_interrupt_instr_done),
		.irq_event(irq_event), .pend_sw_set(pend_sw_set), .pend_sw_clr(pend_sw_clr),
		.irq_enable(irq_enable), .irq_high_prio(irq_high_prio),
		.global_interrupt_enable(global_interrupt_enable), .data_pointer(data_pointer),
		.accumulator(accumulator), .second_accumulator(second_accumulator),
		.program_status_word(program_status_word), .bank_base(bank_base),
		.pend_flags(pend_flags), .call_busy(call_busy), .vec_valid(vec_valid),
		.vec_addr(vec_addr), .vec_src(vec_src), .in_high_isr(in_high_isr),
		.in_low_isr(in_low_isr));
	cse_src_model cse_src_model_inst (.clk(clk), .rst_n(rst_n), .fire(fire),
		.fire_mask(fire_mask), .irq_event(irq_event));

	// ------------------------------------------------------------------
	// Access tasks
	// ------------------------------------------------------------------
	task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge clk);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge clk);
		sfr_wr <= 1'b0;
	endtask : wr
	task automatic rd(logic [7:0] a, logic [7:0] exp);
		@(posedge clk);
		sfr_addr <= a;
		@(posedge clk);
		@(negedge clk);
		chk("sfr_rdata", {8'h00, sfr_rdata}, {8'h00, exp});
	endtask : rd
	task automatic alu_case(cse_pkg::cse_op_t op, logic [7:0] p, a, b, s, ea, eb, ep);
		wr(8'hD0, p);
		wr(8'hE0, a);
		wr(8'hF0, b);
		@(posedge clk);
		alu_valid <= 1'b1;
		alu_op <= op;
		alu_src <= s;
		@(posedge clk);
		alu_valid <= 1'b0;
		@(negedge clk);
		chk("accumulator", {8'h00, accumulator}, {8'h00, ea});
		chk("second_accumulator", {8'h00, second_accumulator}, {8'h00, eb});
		chk("program_status_word", {8'h00, program_status_word}, {8'h00, ep});
	endtask : alu_case
	task automatic ev(logic [N-1:0] m);
		@(posedge clk);
		fire <= 1'b1;
		fire_mask <= m;
		@(posedge clk);
		fire <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : ev
	task automatic take(logic exp, logic [4:0] s);
		logic got = 1'b0;
		repeat (2) @(posedge clk);
		instr_done <= 1'b1;
		@(posedge clk);
		instr_done <= 1'b0;
		for (int i = 0; i < 10; i++) begin
			@(negedge clk);
			if (vec_valid === 1'b1) got = 1'b1;
		end
		chk("vec_valid", {15'h0000, got}, {15'h0000, exp});
		if (exp) begin
			chk("vec_src", {11'h000, vec_src}, {11'h000, s});
			chk("vec_addr", vec_addr, 16'h0003 + 16'(s) * 16'h0008);
		end
	endtask : take
	task automatic ret(logic clr);
		@(posedge clk);
		pend_sw_clr <= clr ? '1 : '0;
		@(posedge clk);
		pend_sw_clr <= '0;
		return_from_interrupt_instr_done <= 1'b1;
		@(posedge clk);
		return_from_interrupt_instr_done <= 1'b0;
	endtask : ret
	task automatic stop_test();
		if (err_total == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test

	// ------------------------------------------------------------------
	// Clock, watchdog and tests
	// ------------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		#200_000;
		err_total++;
		stop_test();
	end
	initial begin
		{rst_n, sfr_wr, alu_valid, instr_done, return_from_interrupt_instr_done, fire} = '0;
		{sfr_addr, sfr_wdata, alu_src, fire_mask, pend_sw_set, pend_sw_clr} = '0;
		alu_op = cse_pkg::CSE_OP_NONE;
		irq_enable = '1;
		irq_high_prio = '0;
		global_interrupt_enable = 1'b1;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		for (int i = 0; i < 6; i++) rd(regs[i], 8'h00);
		wr(8'hE0, 8'h06);
		wr(8'hD0, 8'hFF);
		rd(8'hD0, 8'hFE);
		wr(8'hE0, 8'h07);
		rd(8'hD0, 8'hFF);
		for (int b = 0; b < 4; b++) begin
			wr(8'hD0, 8'(b << 3));
			@(negedge clk);
			chk("bank_base", {11'h000, bank_base}, 16'(b * 8));
		end
		wr(8'h82, 8'h34);
		wr(8'h83, 8'h12);
		@(negedge clk);
		chk("data_pointer", data_pointer, 16'h1234);
		alu_case(cse_pkg::CSE_OP_ADD, 8'h22, 8'h7F, 8'h00, 8'h01, 8'h80, 8'h00, 8'h67);
		alu_case(cse_pkg::CSE_OP_ADD, 8'h00, 8'hFF, 8'h00, 8'h01, 8'h00, 8'h00, 8'hC0);
		alu_case(cse_pkg::CSE_OP_ADD_WITH_CARRY_INSTR, 8'h80, 8'h80, 8'h00, 8'h7F, 8'h00, 8'h00, 8'hC0);
		alu_case(cse_pkg::CSE_OP_SUBTRACT_WITH_BORROW_INSTR, 8'h80, 8'h00, 8'h00, 8'h01, 8'hFE, 8'h00, 8'hC1);
		alu_case(cse_pkg::CSE_OP_SUBTRACT_WITH_BORROW_INSTR, 8'h00, 8'h80, 8'h00, 8'h01, 8'h7F, 8'h00, 8'h45);
		alu_case(cse_pkg::CSE_OP_MUL, 8'h00, 8'h20, 8'h10, 8'h00, 8'h00, 8'h02, 8'h04);
		alu_case(cse_pkg::CSE_OP_MUL, 8'hC4, 8'h0F, 8'h11, 8'h00, 8'hFF, 8'h00, 8'h00);
		alu_case(cse_pkg::CSE_OP_DIV, 8'hC0, 8'h07, 8'h00, 8'h00, 8'h07, 8'h00, 8'h05);
		alu_case(cse_pkg::CSE_OP_DIV, 8'h04, 8'h07, 8'h02, 8'h00, 8'h03, 8'h01, 8'h00);
		alu_case(cse_pkg::CSE_OP_NONE, 8'h20, 8'h05, 8'h09, 8'h01, 8'h05, 8'h09, 8'h20);
		ev(22'h1 << 3);
		take(1'b1, 5'd3);
		chk("in_low_isr", {15'h0000, in_low_isr}, 16'h0001);
		ret(1'b0);
		take(1'b1, 5'd3);
		ret(1'b1);
		@(negedge clk);
		chk("in_low_isr", {15'h0000, in_low_isr}, 16'h0000);
		@(posedge clk);
		global_interrupt_enable <= 1'b0;
		ev(22'h1 << 5);
		chk("pend_flags", 16'(pend_flags[5]), 16'h0001);
		take(1'b0, 5'd0);
		@(posedge clk);
		global_interrupt_enable <= 1'b1;
		irq_enable <= '0;
		take(1'b0, 5'd0);
		@(posedge clk);
		irq_enable <= '1;
		take(1'b1, 5'd5);
		ret(1'b1);
		ev((22'h1 << 7) | (22'h1 << 4));
		take(1'b1, 5'd4);
		@(posedge clk);
		irq_high_prio <= 22'h1 << 9;
		ev(22'h1 << 9);
		take(1'b1, 5'd9);
		chk("in_high_isr", {15'h0000, in_high_isr}, 16'h0001);
		ev(22'h1 << 2);
		take(1'b0, 5'd0);
		ret(1'b1);
		ret(1'b1);
		@(posedge clk);
		pend_sw_set <= 22'h1 << 6;
		@(posedge clk);
		pend_sw_set <= '0;
		take(1'b1, 5'd6);
		ret(1'b1);
		@(posedge clk);
		fire <= 1'b1;
		fire_mask <= 22'h1 << 8;
		@(posedge clk);
		fire <= 1'b0;
		pend_sw_clr <= 22'h1 << 8;
		@(posedge clk);
		pend_sw_clr <= '0;
		@(negedge clk);
		chk("pend_flags", 16'(pend_flags[8]), 16'h0001);
		stop_test();
	end
endmodule : cse_core_tb
